// >>> rtl/cat_pkg.sv
`default_nettype none
// Shared constants and types for the cascadable auxiliary timers.
package cat_pkg;

  // Bus shape and timer count.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int NUM_TIMERS = 3;
  localparam int OUTS_PER_TIMER = 2;

  // Register word addresses; a timer's length and threshold pairs step by LEN_THR_STRIDE.
  localparam int ADDR_MODE_BASE = 32'h00;
  localparam int ADDR_LEN_BASE = 32'h03;
  localparam int ADDR_THR_BASE = 32'h04;
  localparam int LEN_THR_STRIDE = 2;
  localparam logic [ADDR_W-1:0] ADDR_GATE = 5'h09;
  localparam int ADDR_OUTSEL_BASE = 32'h0A;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h0D;
  localparam int ADDR_COUNT_BASE = 32'h0E;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STS = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h12;

  // Reset values.
  localparam logic [DATA_W-1:0] MODE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] LEN_RST = 16'h7530;
  localparam logic [DATA_W-1:0] THR_RST = 16'h2710;
  localparam logic [DATA_W-1:0] GATE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] OUTSEL_RST = 16'h0041;
  localparam logic [2*NUM_TIMERS-1:0] IRQ_MASK_RST = 6'h00;

  // Field positions: one nibble per field.
  localparam int NIB_W = 4;
  localparam int STATUS_NIB_W = 4;

  // Clock select codes.
  localparam logic [3:0] CLK_MS = 4'h0;
  localparam logic [3:0] CLK_SEC = 4'h1;
  localparam logic [3:0] CLK_MIN = 4'h2;
  localparam logic [3:0] CLK_T1_CYC = 4'h3;
  localparam logic [3:0] CLK_T2_CYC = 4'h4;

  // Start select codes.
  localparam logic [3:0] START_TERM = 4'h0;
  localparam logic [3:0] START_RUN = 4'h1;
  localparam logic [3:0] START_STOP = 4'h2;
  localparam logic [3:0] START_SYNC_T1 = 4'h3;
  localparam logic [3:0] START_T1_CYC = 4'h4;
  localparam logic [3:0] START_T2_CYC = 4'h5;

  // Reset select codes.
  localparam logic [3:0] RST_TERM = 4'h0;
  localparam logic [3:0] RST_AUTO_CYC = 4'h1;
  localparam logic [3:0] RST_AUTO_STOP = 4'h2;

  // Timing cycle codes.
  localparam logic [3:0] CYCLE_SINGLE = 4'h0;
  localparam logic [3:0] CYCLE_MULTI = 4'h1;

  // Gate select codes.
  localparam logic [3:0] GATE_NONE = 4'h0;
  localparam logic [3:0] GATE_TERM = 4'h1;
  localparam logic [3:0] GATE_T1_CMP = 4'h2;
  localparam logic [3:0] GATE_T1_CYC = 4'h3;
  localparam logic [3:0] GATE_T2_CMP = 4'h4;
  localparam logic [3:0] GATE_T2_CYC = 4'h5;

  // Output signal codes.
  localparam logic [3:0] OUT_CMP_PULSE = 4'h0;
  localparam logic [3:0] OUT_CMP_LEVEL = 4'h1;
  localparam logic [3:0] OUT_CMP_TOG = 4'h2;
  localparam logic [3:0] OUT_CYC_PULSE = 4'h3;
  localparam logic [3:0] OUT_CYC_LEVEL = 4'h4;
  localparam logic [3:0] OUT_CYC_TOG = 4'h5;
  localparam logic [3:0] OUT_ANY_TOG = 4'h6;

  // Timing: base tick of 1 ms at a 5 ns clock, slower ticks counted in ms and s.
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_MS_NS = 1000000;
  localparam int MS_TICK_CYCLES = TICK_MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_SEC = 1000;
  localparam int SEC_PER_MIN = 60;
  localparam int PULSE_TIME_MS = 500;

  // Mode word, high nibble first.
  typedef struct packed {
    logic [3:0] cycle_mode;
    logic [3:0] reset_sel;
    logic [3:0] start_sel;
    logic [3:0] clk_sel;
  } cat_mode_type;

  typedef enum logic [1:0] {
    CAT_IDLE,
    CAT_RUN,
    CAT_DONE
  } cat_state_type;

endpackage
`default_nettype wire

// >>> rtl/cat_timers.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (R1) Clock codes 0,1,2 pick 1ms, 1s, 1min.
// (R2) Timers two, three: code 3 uses timer-one cycles.
// (R3) Timer three: code 4 uses timer-two cycles.
// (R4) Start code 0: terminal start input edge.
// (R5) Start code 1: drive stop-to-run edge.
// (R6) Start code 2: drive run-to-stop edge.
// (R7) Start code 3: start together with timer one.
// (R8) Start codes 4,5: lower timer cycle pulse.
// (R9) Reset clears count, status; code 0 terminal.
// (R10) Automatic reset clears when cycle length reached.
// (R11) Reset code 2 clears when timer stops.
// (R12) Single cycle halts until reset and retrigger.
// (R13) Multi cycle wraps and continues without trigger.
// (R14) Cycle length 0 to 65535, default 30000.
// (R15) Threshold up to cycle length, default 10000.
// (R16) Outputs: compare/cycle as pulse, level, toggle.
// (R17) Optional gating by terminal or lower timer.
// (R18) Compare event and one-tick cycle pulse.
module cat_timers #(
  parameter int P_MS_CYCLES = cat_pkg::MS_TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [cat_pkg::ADDR_W-1:0] i_addr,
  input wire logic [cat_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [cat_pkg::DATA_W-1:0] o_rdata,
  input wire logic [cat_pkg::NUM_TIMERS-1:0] i_start_term,
  input wire logic [cat_pkg::NUM_TIMERS-1:0] i_reset_term,
  input wire logic [cat_pkg::NUM_TIMERS-1:0] i_gate_term,
  input wire logic i_drive_run,
  output logic [cat_pkg::NUM_TIMERS*cat_pkg::OUTS_PER_TIMER-1:0] o_timer_out,
  output logic o_irq
);
  import cat_pkg::*;

  localparam int MS_W = $clog2(P_MS_CYCLES);
  localparam int SEC_W = $clog2(MS_PER_SEC);
  localparam int MIN_W = $clog2(SEC_PER_MIN);
  localparam int PULSE_W = $clog2(PULSE_TIME_MS + 1);
  localparam int NOUT = NUM_TIMERS * OUTS_PER_TIMER;

  // The divider needs at least two cycles per tick to make a one-cycle enable.
  if (P_MS_CYCLES < 2) begin : g_bad_ms
    $error("P_MS_CYCLES must be at least 2");
  end

  // Clock source decode for one timer; cascade codes only exist above timer one.
  function automatic logic sel_clock(input logic [3:0] sel, input int idx, input logic t_ms,
                                     input logic t_s, input logic t_min, input logic [NUM_TIMERS-1:0] cyc);
    logic r;
    r = 1'b0;
    case (sel)
      CLK_MS: r = t_ms; // R1
      CLK_SEC: r = t_s; // R1
      CLK_MIN: r = t_min; // R1
      CLK_T1_CYC: r = (idx >= 1) && cyc[0]; // R2
      CLK_T2_CYC: r = (idx == 2) && cyc[1]; // R3
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Start trigger decode for one timer.
  function automatic logic sel_start(input logic [3:0] sel, input int idx, input logic term_edge,
                                     input logic rise, input logic fall, input logic t1_start,
                                     input logic [NUM_TIMERS-1:0] cyc);
    logic r;
    r = 1'b0;
    case (sel)
      START_TERM: r = term_edge; // R4
      START_RUN: r = rise; // R5
      START_STOP: r = fall; // R6
      START_SYNC_T1: r = (idx >= 1) && t1_start; // R7
      START_T1_CYC: r = (idx >= 1) && cyc[0]; // R8
      START_T2_CYC: r = (idx == 2) && cyc[1]; // R8
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Gate decode; an unsupported code closes the gate rather than letting the timer run free.
  function automatic logic sel_gate(input logic [3:0] sel, input int idx, input logic term,
                                    input logic [NUM_TIMERS-1:0] cmp_f, input logic [NUM_TIMERS-1:0] cyc_f);
    logic r;
    r = 1'b0;
    case (sel)
      GATE_NONE: r = 1'b1; // R17
      GATE_TERM: r = term; // R17
      GATE_T1_CMP: r = (idx >= 1) && cmp_f[0]; // R17
      GATE_T1_CYC: r = (idx >= 1) && cyc_f[0]; // R17
      GATE_T2_CMP: r = (idx == 2) && cmp_f[1]; // R17
      GATE_T2_CYC: r = (idx == 2) && cyc_f[1]; // R17
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Shared tick chain: ms from the clock, seconds from ms, minutes from seconds.
  logic [MS_W-1:0] ms_cnt;
  logic [SEC_W-1:0] sec_cnt;
  logic [MIN_W-1:0] min_cnt;
  wire logic ms_tick;
  wire logic sec_tick;
  wire logic min_tick;
  assign ms_tick = (ms_cnt == MS_W'(P_MS_CYCLES - 1));
  assign sec_tick = ms_tick && (sec_cnt == SEC_W'(MS_PER_SEC - 1));
  assign min_tick = sec_tick && (min_cnt == MIN_W'(SEC_PER_MIN - 1));

  // Free-running dividers; the enables are one cycle wide.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ms_cnt <= '0;
      sec_cnt <= '0;
      min_cnt <= '0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + MS_W'(1);
      if (ms_tick) begin
        sec_cnt <= sec_tick ? '0 : sec_cnt + SEC_W'(1);
      end
      if (sec_tick) begin
        min_cnt <= min_tick ? '0 : min_cnt + MIN_W'(1);
      end
    end
  end

  // Edge detection of the drive run state and the start terminals.
  logic run_prev;
  logic [NUM_TIMERS-1:0] start_prev;
  wire logic run_rise;
  wire logic run_fall;
  wire logic [NUM_TIMERS-1:0] start_edge;
  assign run_rise = i_drive_run && !run_prev;
  assign run_fall = !i_drive_run && run_prev;
  assign start_edge = i_start_term & ~start_prev;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      run_prev <= 1'b0;
      start_prev <= '0;
    end else begin
      run_prev <= i_drive_run;
      start_prev <= i_start_term;
    end
  end

  // Per-timer signals shared across the cascade.
  wire logic [NUM_TIMERS-1:0] start_evt;
  wire logic [NUM_TIMERS-1:0] cyc_pulse;
  wire logic [NUM_TIMERS-1:0] cmp_pulse;
  wire logic [NUM_TIMERS-1:0] cmp_flag;
  wire logic [NUM_TIMERS-1:0] cyc_flag;
  wire logic [NUM_TIMERS*STATUS_NIB_W-1:0] status_word;
  wire logic [DATA_W-1:0] rd_part [NUM_TIMERS];
  wire logic [NOUT-1:0] next_out;
  logic [DATA_W-1:0] gate_reg;
  wire logic gate_hit;
  assign gate_hit = (i_addr == ADDR_GATE);

  for (genvar k = 0; k < NUM_TIMERS; k++) begin : g_tmr
    localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'(ADDR_MODE_BASE + k);
    localparam logic [ADDR_W-1:0] A_LEN = ADDR_W'(ADDR_LEN_BASE + LEN_THR_STRIDE * k);
    localparam logic [ADDR_W-1:0] A_THR = ADDR_W'(ADDR_THR_BASE + LEN_THR_STRIDE * k);
    localparam logic [ADDR_W-1:0] A_OSEL = ADDR_W'(ADDR_OUTSEL_BASE + k);
    localparam logic [ADDR_W-1:0] A_CNT = ADDR_W'(ADDR_COUNT_BASE + k);

    cat_mode_type mode_q;
    logic [DATA_W-1:0] len_q;
    logic [DATA_W-1:0] thr_q;
    logic [DATA_W-1:0] osel_q;
    logic [DATA_W-1:0] count_q;
    cat_state_type state_q;
    logic cmp_q;
    logic cyc_q;

    // Configuration write decode.
    wire logic wr_mode;
    wire logic wr_len;
    wire logic wr_thr;
    wire logic wr_osel;
    wire logic [DATA_W-1:0] thr_clamped;
    assign wr_mode = i_wr && (i_addr == A_MODE);
    assign wr_len = i_wr && (i_addr == A_LEN);
    assign wr_thr = i_wr && (i_addr == A_THR);
    assign wr_osel = i_wr && (i_addr == A_OSEL);
    assign thr_clamped = (i_wdata > len_q) ? len_q : i_wdata; // R15

    // Length takes the full 16-bit range; a threshold above the length is clamped to it.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
        mode_q <= cat_mode_type'(MODE_RST);
        len_q <= LEN_RST; // R14
        thr_q <= THR_RST; // R15
        osel_q <= OUTSEL_RST;
      end else begin
        if (wr_mode) begin
          mode_q <= cat_mode_type'(i_wdata);
        end
        if (wr_len) begin
          len_q <= i_wdata; // R14
        end
        if (wr_thr) begin
          thr_q <= thr_clamped; // R15
        end
        if (wr_osel) begin
          osel_q <= i_wdata;
        end
      end
    end

    // Count advance and events; the cascade reads only lower timers, so no loop forms.
    wire logic src_tick;
    wire logic gate_ok;
    wire logic adv;
    wire logic [DATA_W:0] count_inc;
    wire logic reach_cyc;
    wire logic hit_cmp;
    wire logic ext_reset;
    wire logic halts;
    wire logic auto_clear;
    wire logic [NUM_TIMERS-1:0] low_cyc;
    wire logic t1_start;
    // Only lower timers reach this one; a timer never sees its own pulse, so no combinational loop forms.
    for (genvar b = 0; b < NUM_TIMERS; b++) begin : g_low
      if (b < k) begin : g_on
        assign low_cyc[b] = cyc_pulse[b];
      end else begin : g_off
        assign low_cyc[b] = 1'b0;
      end
    end
    if (k == 0) begin : g_first
      assign t1_start = 1'b0;
    end else begin : g_upper
      assign t1_start = start_evt[0]; // R7
    end
    assign src_tick = sel_clock(mode_q.clk_sel, k, ms_tick, sec_tick, min_tick, low_cyc);
    assign gate_ok = sel_gate(gate_reg[NIB_W*k +: NIB_W], k, i_gate_term[k], cmp_flag, cyc_flag);
    assign adv = (state_q == CAT_RUN) && gate_ok && src_tick;
    assign count_inc = {1'b0, count_q} + {{DATA_W{1'b0}}, 1'b1};
    assign reach_cyc = adv && (count_inc >= {1'b0, len_q}); // R18
    assign hit_cmp = adv && (count_inc == {1'b0, thr_q}); // R18
    assign ext_reset = (mode_q.reset_sel == RST_TERM) && i_reset_term[k]; // R9
    assign halts = reach_cyc && (mode_q.cycle_mode != CYCLE_MULTI); // R12
    assign auto_clear = (reach_cyc && (mode_q.reset_sel == RST_AUTO_CYC)) // R10
                        || (halts && (mode_q.reset_sel == RST_AUTO_STOP)); // R11
    assign start_evt[k] = (state_q == CAT_IDLE) && !ext_reset
                          && sel_start(mode_q.start_sel, k, start_edge[k], run_rise, run_fall, t1_start, low_cyc);
    assign cyc_pulse[k] = reach_cyc; // R18
    assign cmp_pulse[k] = hit_cmp; // R18
    assign cmp_flag[k] = cmp_q;
    assign cyc_flag[k] = cyc_q;
    assign status_word[STATUS_NIB_W*k +: STATUS_NIB_W] = {state_q == CAT_DONE, state_q == CAT_RUN, cyc_q, cmp_q};

    // With terminal reset selected, a finished single cycle parks in DONE until a reset; the automatic reset codes return it straight to IDLE.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
        count_q <= '0;
        state_q <= CAT_IDLE;
        cmp_q <= 1'b0;
        cyc_q <= 1'b0;
      end else if (ext_reset) begin
        count_q <= '0; // R9
        state_q <= CAT_IDLE;
        cmp_q <= 1'b0;
        cyc_q <= 1'b0;
      end else if (start_evt[k]) begin
        state_q <= CAT_RUN;
      end else if (auto_clear) begin
        count_q <= '0; // R10 R11
        cmp_q <= 1'b0;
        cyc_q <= 1'b0;
        state_q <= halts ? CAT_IDLE : CAT_RUN;
      end else if (reach_cyc) begin
        cyc_q <= 1'b1;
        cmp_q <= cmp_q || hit_cmp;
        if (halts) begin
          count_q <= count_inc[DATA_W-1:0]; // R12
          state_q <= CAT_DONE;
        end else begin
          count_q <= '0; // R13
        end
      end else if (adv) begin
        count_q <= count_inc[DATA_W-1:0];
        cmp_q <= cmp_q || hit_cmp;
      end
    end

    // Read contribution of this timer.
    assign rd_part[k] = ((i_addr == A_MODE) ? DATA_W'(mode_q) : '0)
                        | ((i_addr == A_LEN) ? len_q : '0)
                        | ((i_addr == A_THR) ? thr_q : '0)
                        | ((i_addr == A_OSEL) ? osel_q : '0)
                        | ((i_addr == A_CNT) ? count_q : '0);

    // Two output signals per timer; the pulse length is counted in ms ticks.
    for (genvar j = 0; j < OUTS_PER_TIMER; j++) begin : g_out
      wire logic [3:0] code;
      wire logic pulse_trig;
      wire logic tog_trig;
      logic [PULSE_W-1:0] pulse_left;
      logic tog_q;
      logic out_val;
      assign code = osel_q[NIB_W*j +: NIB_W];
      assign pulse_trig = ((code == OUT_CMP_PULSE) && hit_cmp) || ((code == OUT_CYC_PULSE) && reach_cyc);
      assign tog_trig = ((code == OUT_CMP_TOG) && hit_cmp) || ((code == OUT_CYC_TOG) && reach_cyc)
                        || ((code == OUT_ANY_TOG) && (hit_cmp || reach_cyc));

      // A retrigger restarts the pulse, so it never ends early.
      always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
          pulse_left <= '0;
          tog_q <= 1'b0;
        end else begin
          if (pulse_trig) begin
            pulse_left <= PULSE_W'(PULSE_TIME_MS); // R16
          end else if (ms_tick && (pulse_left != '0)) begin
            pulse_left <= pulse_left - PULSE_W'(1);
          end
          if (tog_trig) begin
            tog_q <= !tog_q; // R16
          end
        end
      end

      always_comb begin
        case (code)
          OUT_CMP_PULSE: out_val = (pulse_left != '0); // R16
          OUT_CYC_PULSE: out_val = (pulse_left != '0); // R16
          OUT_CMP_LEVEL: out_val = cmp_q; // R16
          OUT_CYC_LEVEL: out_val = cyc_q; // R16
          OUT_CMP_TOG: out_val = tog_q;
          OUT_CYC_TOG: out_val = tog_q;
          OUT_ANY_TOG: out_val = tog_q;
          default: out_val = 1'b0;
        endcase
      end
      assign next_out[OUTS_PER_TIMER*k + j] = out_val;
    end
  end

  // Interrupt status: bit k is compare of timer k, bit NUM_TIMERS+k its cycle event.
  logic [2*NUM_TIMERS-1:0] irq_sts;
  logic [2*NUM_TIMERS-1:0] irq_mask;
  wire logic [2*NUM_TIMERS-1:0] irq_evt;
  wire logic [2*NUM_TIMERS-1:0] irq_clr;
  wire logic [2*NUM_TIMERS-1:0] next_irq_sts;
  assign irq_evt = {cyc_pulse, cmp_pulse};
  assign irq_clr = (i_wr && (i_addr == ADDR_IRQ_STS)) ? i_wdata[2*NUM_TIMERS-1:0] : '0;
  assign next_irq_sts = (irq_sts & ~irq_clr) | irq_evt; // A new event wins over a same-cycle clear.

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      irq_sts <= '0;
      irq_mask <= IRQ_MASK_RST;
      gate_reg <= GATE_RST;
      o_irq <= 1'b0;
    end else begin
      irq_sts <= next_irq_sts;
      if (i_wr && (i_addr == ADDR_IRQ_MASK)) begin
        irq_mask <= i_wdata[2*NUM_TIMERS-1:0];
      end
      if (i_wr && gate_hit) begin
        gate_reg <= i_wdata;
      end
      o_irq <= |(irq_sts & irq_mask);
    end
  end

  // Read selection; unmapped addresses read as zero.
  wire logic [DATA_W-1:0] rd_common;
  wire logic [DATA_W-1:0] rd_word;
  assign rd_common = (gate_hit ? gate_reg : '0)
                     | ((i_addr == ADDR_STATUS) ? DATA_W'(status_word) : '0)
                     | ((i_addr == ADDR_IRQ_STS) ? DATA_W'(irq_sts) : '0)
                     | ((i_addr == ADDR_IRQ_MASK) ? DATA_W'(irq_mask) : '0);
  assign rd_word = rd_common | rd_part[0] | rd_part[1] | rd_part[2];

  // Read data stand only in the cycle after the strobe; outputs are registered.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= '0;
      o_timer_out <= '0;
    end else begin
      o_rdata <= i_rd ? rd_word : '0;
      o_timer_out <= next_out;
    end
  end

endmodule
`default_nettype wire

// >>> test/cat_timers_chk.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checker for the timers; a shadow of the mask lets the interrupt be judged from outside.
module cat_timers_chk
  import cat_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [NUM_TIMERS-1:0] i_reset_term,
  input wire logic [NUM_TIMERS*OUTS_PER_TIMER-1:0] o_timer_out,
  input wire logic o_irq
);
  logic [5:0] mask_sh;
  // The shadow follows mask writes exactly as software sees them.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      mask_sh <= 6'h00;
    end else if (i_wr && i_addr == ADDR_IRQ_MASK) begin
      mask_sh <= i_wdata[5:0];
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (i_rd && i_addr > 5'h12 |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_status_top_zero: assert property (i_rd && i_addr == ADDR_STATUS |=> o_rdata[15:12] == 4'h0)
    else $error("status spare bits set");
  a_irq_sts_width: assert property (i_rd && i_addr == ADDR_IRQ_STS |=> o_rdata[15:6] == 10'h000)
    else $error("event status spare bits set");
  a_mask_readback: assert property (i_rd && i_addr == ADDR_IRQ_MASK |=> o_rdata == {10'h000, mask_sh})
    else $error("mask read differs from last write");
  a_irq_masked_low: assert property ($past(mask_sh) == 6'h00 |-> !o_irq)
    else $error("interrupt high with all events masked");
  // Valid only while timer one keeps terminal reset selected, as the bench arranges.
  a_term_clears_count: assert property (i_reset_term[0] [*2] ##0 (i_rd && i_addr == 5'h0E)
    |=> o_rdata == 16'h0000)
    else $error("count not cleared by terminal reset");
  a_term_clears_out: assert property (i_reset_term[0] [*3] |-> o_timer_out[1:0] == 2'b00)
    else $error("level outputs not cleared by terminal reset");
endmodule
bind cat_timers cat_timers_chk u_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_reset_term(i_reset_term),
  .o_timer_out(o_timer_out), .o_irq(o_irq));
`default_nettype wire

// >>> test/cascadable_aux_timers_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Register-level tests of the three timers; a 4-cycle millisecond tick keeps runs short.
module cascadable_aux_timers_tb_top;
  import cat_pkg::*;
  localparam logic [15:0] RST_TAB [20] = '{16'h0, 16'h0, 16'h0, 16'h7530, 16'h2710, 16'h7530, 16'h2710,
    16'h7530, 16'h2710, 16'h0, 16'h41, 16'h41, 16'h41, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic i_clk_sys, i_reset, i_wr, i_rd, i_drive_run, o_irq;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata, d;
  logic [NUM_TIMERS-1:0] i_start_term, i_reset_term, i_gate_term;
  logic [5:0] o_timer_out;
  int fails, check_count;
  cat_timers #(.P_MS_CYCLES(4)) u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_start_term(i_start_term),
    .i_reset_term(i_reset_term), .i_gate_term(i_gate_term), .i_drive_run(i_drive_run),
    .o_timer_out(o_timer_out), .o_irq(o_irq));
  // Free-running system clock.
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // Strobes drop one edge after they rise, so a following call never meets them in the same step.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // Exact checks pass the same bound twice; ranges absorb the free-running tick phase.
  task automatic cmp(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    rd(a);
    cmp(d, e, e);
  endtask
  task automatic kick;
    @(posedge i_clk_sys);
    i_start_term[0] <= 1'b1;
    @(posedge i_clk_sys);
    i_start_term[0] <= 1'b0;
  endtask
  task automatic rst(input int n);
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    cyc(n);
    i_reset <= 1'b0;
  endtask
  task automatic test_done;
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // A hang is cut off well beyond the few thousand cycles the tests need.
  initial begin
    cyc(20000);
    fails++;
    test_done();
  end
  initial begin
    i_reset = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_start_term = '0;
    i_reset_term = '0;
    i_gate_term = '0;
    i_drive_run = 1'b0;
    fails = 0;
    check_count = 0;
    cyc(16);
    i_reset <= 1'b0;
    for (int a = 0; a < 20; a++) begin
      rc(a[4:0], RST_TAB[a]);
    end
    wr(5'h0E, 16'h1234);
    wr(5'h13, 16'hFFFF);
    rc(5'h0E, 16'h0000);
    // Single cycle on millisecond ticks with terminal start, then retrigger and terminal reset.
    wr(5'h03, 16'h0003);
    wr(5'h04, 16'h0002);
    wr(ADDR_IRQ_MASK, 16'h003F);
    rc(ADDR_IRQ_MASK, 16'h003F);
    kick();
    cyc(40);
    rc(5'h0E, 16'h0003);
    rc(ADDR_STATUS, 16'h000B);
    rc(ADDR_IRQ_STS, 16'h0009);
    cmp({15'h0, o_irq}, 16'h1, 16'h1);
    cmp({14'h0, o_timer_out[1:0]}, 16'h3, 16'h3);
    kick();
    cyc(20);
    rc(5'h0E, 16'h0003);
    @(posedge i_clk_sys);
    i_reset_term[0] <= 1'b1;
    rc(5'h0E, 16'h0000);
    cyc(2);
    i_reset_term[0] <= 1'b0;
    rc(ADDR_STATUS, 16'h0000);
    cmp({14'h0, o_timer_out[1:0]}, 16'h0, 16'h0);
    wr(ADDR_IRQ_STS, 16'h0009);
    rc(ADDR_IRQ_STS, 16'h0000);
    cyc(2);
    #1;
    cmp({15'h0, o_irq}, 16'h0, 16'h0);
    // Cascade: timer one repeats, timer two counts its cycles, timer three counts timer two's.
    rst(2);
    wr(5'h00, 16'h1100);
    wr(5'h03, 16'h0002);
    wr(5'h01, 16'h1133);
    wr(5'h05, 16'h0002);
    wr(5'h02, 16'h0034);
    kick();
    cyc(80);
    rd(5'h0E);
    cmp(d, 16'h0, 16'h1);
    rd(5'h0F);
    cmp(d, 16'h0, 16'h1);
    rd(5'h10);
    cmp(d, 16'h4, 16'h6);
    rd(ADDR_STATUS);
    cmp(d & 16'h0444, 16'h0444, 16'h0444);
    rc(5'h01, 16'h1133);
    // Drive run edges start timers one and three; timer two follows timer one's cycle.
    rst(2);
    wr(5'h00, 16'h0010);
    wr(5'h03, 16'h0001);
    wr(5'h01, 16'h0040);
    wr(5'h05, 16'h0008);
    wr(5'h02, 16'h0220);
    wr(5'h07, 16'h0001);
    @(posedge i_clk_sys);
    i_drive_run <= 1'b1;
    cyc(20);
    rc(5'h0E, 16'h0001);
    rd(ADDR_STATUS);
    cmp(d & 16'h0040, 16'h0040, 16'h0040);
    @(posedge i_clk_sys);
    i_drive_run <= 1'b0;
    cyc(60);
    rc(5'h10, 16'h0000);
    rc(5'h0F, 16'h0008);
    rc(ADDR_STATUS, 16'h00AA);
    rc(ADDR_IRQ_STS, 16'h0038);
    // Gate and output styles: timer one waits on its gate terminal and toggles, timer two pulses for 500 ms.
    rst(2);
    wr(ADDR_GATE, 16'h0001);
    wr(5'h03, 16'h0004);
    wr(5'h04, 16'h0002);
    wr(5'h05, 16'h0004);
    wr(5'h06, 16'h0002);
    wr(5'h01, 16'h0030);
    wr(5'h0A, 16'h0052);
    wr(5'h0B, 16'h0030);
    kick();
    cyc(20);
    rc(5'h0E, 16'h0000);
    cmp({14'h0, o_timer_out[3:2]}, 16'h3, 16'h3);
    @(posedge i_clk_sys);
    i_gate_term[0] <= 1'b1;
    cyc(30);
    rc(5'h0E, 16'h0004);
    cmp({14'h0, o_timer_out[1:0]}, 16'h3, 16'h3);
    // The pulses must still stand near 1900 cycles and be gone after 2100; 500 ms ticks are 2000 cycles here.
    cyc(1840);
    #1;
    cmp({14'h0, o_timer_out[3:2]}, 16'h3, 16'h3);
    cyc(260);
    #1;
    cmp({14'h0, o_timer_out[3:2]}, 16'h0, 16'h0);
    test_done();
  end
endmodule
`default_nettype wire
